// >>> rtl/msc_pkg.sv
// Package for the multiplexed converter step configuration registers
package msc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] STEP8_ADDR = 8'h98;
  localparam logic [ADDR_W-1:0] STEP9_ADDR = 8'h99;
  localparam logic [DATA_W-1:0] STEP8_RESET = 16'h0008;
  localparam logic [DATA_W-1:0] STEP9_RESET = 16'h0009;
  localparam int unsigned EN_BIT = 15;
  localparam int unsigned GAIN_HI = 14;
  localparam int unsigned GAIN_LO = 13;
  localparam int unsigned NEG_BIT = 4;
  localparam int unsigned POS_HI = 3;
  localparam int unsigned POS_LO = 0;
  localparam logic [DATA_W-1:0] WRITE_MASK = 16'hE01F;
  localparam logic [3:0] POS_EXT_LAST = 4'h7;
  localparam logic [3:0] POS_TEMP = 4'h8;
  localparam logic [3:0] POS_SHORT = 4'h9;
  localparam logic [3:0] POS_TEST_DAC = 4'hA;
  localparam logic [3:0] POS_ANALOG_SUPPLY_DIV = 4'hE;
  localparam logic [3:0] POS_DIGITAL_SUPPLY_DIV = 4'hF;

  typedef enum logic [1:0] {
    MSC_GAIN_1 = 2'b00,
    MSC_GAIN_2 = 2'b01,
    MSC_GAIN_4 = 2'b10
  } msc_gain_t;

  typedef enum logic [1:0] {
    MSC_NEG_GROUND = 2'b00,
    MSC_NEG_EXT7 = 2'b01,
    MSC_NEG_AUTO = 2'b10
  } msc_neg_t;

  // Decoded analog routing for one step
  typedef struct packed {
    logic step_enable_bit;
    msc_gain_t gain;
    msc_neg_t neg;
    logic [3:0] pos;
    logic pos_internal;
    logic ext_disconnect;
  } msc_route_t;
endpackage : msc_pkg

// >>> rtl/msc_step_config.sv
// Step 8 and step 9 configuration registers with routing decode
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bit 15 includes step in scan
// - gain field 00=1, 01=2, 1x=4
// - bits 12:5 read-only, read zero
// - bit 4 picks ground or input seven
// - codes 0-7 route external input n
// - codes 8,9,A,E,F route internal sources
// - internal source ignores negative select bit
// - step 9 at 99h, resets 0009h
// - step 8 at 98h, resets 0008h
module msc_step_config
  import msc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output var msc_route_t step8_route_o,
  output var msc_route_t step9_route_o,
  output logic step8_convert_o,
  output logic step9_convert_o
);

  // Stored fields of step 8
  logic step8_enable_bit;
  logic [1:0] step8_gain_field;
  logic step8_neg_input_sel;
  logic [3:0] step8_pos_input_sel;

  // Stored fields of step 9
  logic step9_enable_bit;
  logic [1:0] step9_gain_field;
  logic step9_neg_input_sel;
  logic [3:0] step9_pos_input_sel;

  // Bus decode and read path
  logic wr_step8;
  logic wr_step9;
  logic rd_step8;
  logic rd_step9;
  logic [DATA_W-1:0] step8_word;
  logic [DATA_W-1:0] step9_word;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    return (addr == target);
  endfunction : addr_hit

  // Codes above the last external input pick an internal source
  function automatic logic pos_is_internal(input logic [3:0] pos_sel);
    return (pos_sel > POS_EXT_LAST);
  endfunction : pos_is_internal

  function automatic logic pos_is_short(input logic [3:0] pos_sel);
    return (pos_sel == POS_SHORT);
  endfunction : pos_is_short

  // Both upper gain codes give four
  function automatic msc_gain_t gain_decode(input logic [1:0] gain_field);
    msc_gain_t g;
    case (gain_field)
      2'b00: g = MSC_GAIN_1;
      2'b01: g = MSC_GAIN_2;
      default: g = MSC_GAIN_4;
    endcase
    return g;
  endfunction : gain_decode

  // Internal sources choose their own negative input
  function automatic msc_neg_t neg_decode(input logic neg_input_sel, input logic internal);
    msc_neg_t n;
    if (internal) begin
      n = MSC_NEG_AUTO;
    end else if (neg_input_sel) begin
      n = MSC_NEG_EXT7;
    end else begin
      n = MSC_NEG_GROUND;
    end
    return n;
  endfunction : neg_decode

  function automatic msc_route_t build_route(
    input logic enable_bit,
    input logic [1:0] gain_field,
    input logic neg_input_sel,
    input logic [3:0] pos_input_sel
  );
    msc_route_t r;
    r.step_enable_bit = enable_bit;
    r.gain = gain_decode(gain_field);
    r.neg = neg_decode(neg_input_sel, pos_is_internal(pos_input_sel));
    r.pos = pos_input_sel;
    r.pos_internal = pos_is_internal(pos_input_sel);
    r.ext_disconnect = pos_is_short(pos_input_sel);
    return r;
  endfunction : build_route

  // Reserved bits are not stored and read as zero
  function automatic logic [DATA_W-1:0] pack_word(
    input logic enable_bit,
    input logic [1:0] gain_field,
    input logic neg_input_sel,
    input logic [3:0] pos_input_sel
  );
    logic [DATA_W-1:0] w;
    w = 16'h0000;
    w[EN_BIT] = enable_bit;
    w[GAIN_HI:GAIN_LO] = gain_field;
    w[NEG_BIT] = neg_input_sel;
    w[POS_HI:POS_LO] = pos_input_sel;
    return w;
  endfunction : pack_word

  assign wr_step8 = wr_i && addr_hit(addr_i, STEP8_ADDR);
  assign wr_step9 = wr_i && addr_hit(addr_i, STEP9_ADDR);
  assign rd_step8 = rd_i && addr_hit(addr_i, STEP8_ADDR);
  assign rd_step9 = rd_i && addr_hit(addr_i, STEP9_ADDR);

  assign step8_word = pack_word(
    step8_enable_bit,
    step8_gain_field,
    step8_neg_input_sel,
    step8_pos_input_sel
  );
  assign step9_word = pack_word(
    step9_enable_bit,
    step9_gain_field,
    step9_neg_input_sel,
    step9_pos_input_sel
  );
  assign next_rdata = rd_step8 ? step8_word : (rd_step9 ? step9_word : 16'h0000);

  assign step8_route_o = build_route(
    step8_enable_bit,
    step8_gain_field,
    step8_neg_input_sel,
    step8_pos_input_sel
  );
  assign step9_route_o = build_route(
    step9_enable_bit,
    step9_gain_field,
    step9_neg_input_sel,
    step9_pos_input_sel
  );
  assign step8_convert_o = step8_enable_bit;
  assign step9_convert_o = step9_enable_bit;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step8_enable_bit <= STEP8_RESET[EN_BIT];
    end else if (wr_step8) begin
      step8_enable_bit <= wdata_i[EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step8_gain_field <= STEP8_RESET[GAIN_HI:GAIN_LO];
    end else if (wr_step8) begin
      step8_gain_field <= wdata_i[GAIN_HI:GAIN_LO];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step8_neg_input_sel <= STEP8_RESET[NEG_BIT];
    end else if (wr_step8) begin
      step8_neg_input_sel <= wdata_i[NEG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step8_pos_input_sel <= STEP8_RESET[POS_HI:POS_LO];
    end else if (wr_step8) begin
      step8_pos_input_sel <= wdata_i[POS_HI:POS_LO];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step9_enable_bit <= STEP9_RESET[EN_BIT];
    end else if (wr_step9) begin
      step9_enable_bit <= wdata_i[EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step9_gain_field <= STEP9_RESET[GAIN_HI:GAIN_LO];
    end else if (wr_step9) begin
      step9_gain_field <= wdata_i[GAIN_HI:GAIN_LO];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step9_neg_input_sel <= STEP9_RESET[NEG_BIT];
    end else if (wr_step9) begin
      step9_neg_input_sel <= wdata_i[NEG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step9_pos_input_sel <= STEP9_RESET[POS_HI:POS_LO];
    end else if (wr_step9) begin
      step9_pos_input_sel <= wdata_i[POS_HI:POS_LO];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : msc_step_config
`default_nettype wire

// >>> verification/msc_step_config_bench.sv
// Bench for step config registers
`timescale 1ns/1ps
`default_nettype none
module msc_step_config_bench import msc_pkg::*; ;
  logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, p = 0;
  logic [7:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, e, q[$];
  logic [31:0] s = 32'h8874_b682;
  int n_errors = 0, n_compared = 0, n = 0;
  msc_step_config i_dut(.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .step8_route_o(), .step9_route_o(), .step8_convert_o(), .step9_convert_o());
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], ^(v & 32'h8020_0003)};
  endfunction : lfsr_next
  task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value rdata_o expected %h seen %h", exp, got);
    end
  endtask : check_word
  task automatic acc(input logic [1:0] o, input logic [7:0] a, input logic [15:0] d);
    {wr_i, rd_i} <= o;
    addr_i <= a;
    wdata_i <= d;
    if (o[0]) q.push_back(d);
    @(posedge clk_i);
  endtask : acc
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    if (p) begin
      e = q.pop_front();
      check_word(e, rdata_o);
    end
    p <= rd_i;
    if (++n > 400) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    acc(2'b01, STEP8_ADDR, STEP8_RESET);
    acc(2'b01, STEP9_ADDR, STEP9_RESET);
    $display("reset value test done");
    acc(2'b10, 8'h97, 16'hFFFF);
    acc(2'b01, 8'h97, 16'h0000);
    $display("unmapped address test done");
    for (int i = 0; i < 16; i++) begin
      s = lfsr_next(s);
      acc(2'b10, STEP8_ADDR, {s[15:4], i[3:0]});
      acc(2'b01, STEP8_ADDR, {s[15:4], i[3:0]} & WRITE_MASK);
      acc(2'b10, STEP9_ADDR, {s[31:20], i[3:0]});
      acc(2'b01, STEP9_ADDR, {s[31:20], i[3:0]} & WRITE_MASK);
    end
    $display("register test done");
    acc(2'b00, 8'h00, 16'h0000);
    resetn_i <= 0;
    @(posedge clk_i);
    resetn_i <= 1;
    acc(2'b01, STEP8_ADDR, STEP8_RESET);
    acc(2'b01, STEP9_ADDR, STEP9_RESET);
    $display("mid-run reset test done");
    acc(2'b00, 8'h00, 16'h0000);
    acc(2'b00, 8'h00, 16'h0000);
    tally_and_finish;
  end
endmodule : msc_step_config_bench
`default_nettype wire

// >>> verification/msc_step_config_properties.sv
// Checker for step config registers
`timescale 1ns/1ps
`default_nettype none
module msc_chk import msc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire msc_route_t step8_route_o,
  input wire msc_route_t step9_route_o,
  input wire logic step8_convert_o,
  input wire logic step9_convert_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire msc_route_t r = step8_route_o;
  wire logic w = wr_i && addr_i == STEP8_ADDR;
  wire logic v = wr_i && addr_i == STEP9_ADDR;
  en_wr_a: assert property (w |=> r.step_enable_bit == $past(wdata_i[15])) else $error("en");
  gain_map_a: assert property (w |=> r.gain == ($past(wdata_i[14]) ? 2'b10 : $past(wdata_i[14:13])))
    else $error("gain");
  rsv_zero_a: assert property (rd_i |=> rdata_o[12:5] == 8'h00) else $error("rsv");
  neg_sel_a: assert property (w && !wdata_i[3] |=> r.neg == {1'b0, $past(wdata_i[4])})
    else $error("neg");
  pos_sel_a: assert property (w |=> r.pos == $past(wdata_i[3:0])) else $error("pos");
  neg_auto_a: assert property (r.pos[3] |-> r.neg == 2'b10) else $error("auto");
  short_gnd_a: assert property (r.ext_disconnect == (r.pos == 4'h9)) else $error("short");
  rd_back_a: assert property (rd_i && addr_i == STEP8_ADDR |=> rdata_o[3:0] == $past(r.pos))
    else $error("rd");
  step9_pos_a: assert property (v |=> step9_route_o.pos == $past(wdata_i[3:0])) else $error("step 9 pos");
  skip_step8_a: assert property (w |=> step8_convert_o == $past(wdata_i[15])) else $error("step 8 skip");
  skip_step9_a: assert property (v |=> step9_convert_o == $past(wdata_i[15])) else $error("step 9 skip");
endmodule : msc_chk
bind msc_step_config msc_chk i_chk(
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .step8_route_o(step8_route_o),
  .step9_route_o(step9_route_o),
  .step8_convert_o(step8_convert_o),
  .step9_convert_o(step9_convert_o)
);
`default_nettype wire
